// File: design/bcmbs_pkg.sv
// Purpose: Shared constants and types for the message status word writer
// Assumes: 16-bit shared RAM words, one clock
// Notes:   Error bits 11-0 are owned by other logic and pass through
package bcmbs_pkg;
  localparam int DONE_BIT    = 15;
  localparam int BEGUN_BIT   = 14;
  localparam int BUS_BIT     = 13;
  localparam int CODE_BIT    = 12;
  localparam int LOW_ERR_W   = 12;
  localparam int CTL_MC_BIT  = 2;
  localparam int CTL_RR_BIT  = 1;
  localparam int CTL_BC_BIT  = 0;
  localparam logic [4:0] BCAST_ADDR = 5'h1f;
  localparam logic [4:0] SUBADDR_MC0 = 5'h00;
  localparam logic [4:0] SUBADDR_MC1 = 5'h1f;
  localparam logic [4:0] MC_DYN_BUS = 5'h00;
  localparam logic [4:0] MC_TX_STAT = 5'h02;
  localparam logic [4:0] MC_DATA_MIN = 5'h10;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  // Status and time tag word offsets within the message block
  localparam logic [15:0] OFS_STATUS = 16'h0000;
  localparam logic [15:0] OFS_TAG_LO = 16'h0001;
  localparam logic [15:0] OFS_TAG_HI = 16'h0002;

  typedef struct packed {
    logic [4:0] rt;
    logic       tx;
    logic [4:0] sa;
    logic [4:0] wc;
  } bcmbs_cmd_t;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [15:0] data;
  } bcmbs_ram_req_t;

  typedef enum logic [2:0] {
    S_IDLE, S_BEG_STAT, S_BEG_TAG, S_END_STAT, S_END_TAG
  } bcmbs_state_t;
endpackage : bcmbs_pkg

// File: design/bcmbs_fmt_check.sv
// Purpose: Message block coding check of control flags against commands
// Assumes: Command fields decoded per serial bus command layout
// Notes:   Purely combinational; result sampled by the writer
`timescale 1ns/1ps
module bcmbs_fmt_check (
  input  wire logic                 chk_en,
  input  wire logic [2:0]           ctl_flags,
  input  wire bcmbs_pkg::bcmbs_cmd_t cmd1,
  input  wire bcmbs_pkg::bcmbs_cmd_t cmd2,
  output logic                      code_err
);
  logic is_mc;
  logic is_bc;
  logic mc_data;
  logic fmt_bad;
  logic hard_bad;
  logic rr;

  always_comb begin
    is_mc = (cmd1.sa == bcmbs_pkg::SUBADDR_MC0) ||
            (cmd1.sa == bcmbs_pkg::SUBADDR_MC1);
    is_bc = (cmd1.rt == bcmbs_pkg::BCAST_ADDR);
    rr    = ctl_flags[bcmbs_pkg::CTL_RR_BIT];
    mc_data = is_mc && (cmd1.wc >= bcmbs_pkg::MC_DATA_MIN);
    fmt_bad = (ctl_flags[bcmbs_pkg::CTL_MC_BIT] != is_mc) ||
              (ctl_flags[bcmbs_pkg::CTL_BC_BIT] != is_bc);
    hard_bad = 1'b0;
    if (is_bc && !rr && cmd1.tx && !is_mc)
      hard_bad = 1'b1;
    if (is_bc && mc_data && cmd1.tx)
      hard_bad = 1'b1;
    if (is_bc && is_mc && ((cmd1.wc == bcmbs_pkg::MC_DYN_BUS) ||
        (cmd1.wc == bcmbs_pkg::MC_TX_STAT)))
      hard_bad = 1'b1;
    if (rr && (cmd1.tx || !cmd2.tx))
      hard_bad = 1'b1;
    if (rr && (cmd1.wc != cmd2.wc))
      hard_bad = 1'b1;
    code_err = hard_bad || (chk_en && fmt_bad);
  end
endmodule // bcmbs_fmt_check

// File: design/bcmbs_top.sv
// Purpose: Writes the per-message block status word and low time tag words to RAM
// Assumes: Sequencer pulses msg_start / msg_end; RAM accepts on ram_ack
// Notes:   Host may overwrite the word in RAM; we never read it back
`timescale 1ns/1ps
module bcmbs_top #(
  parameter int TAG_W = 32
) (
  input  wire logic                       sys_clk,
  input  wire logic                       arst_n,
  input  wire logic                       msg_start,
  input  wire logic                       msg_end,
  input  wire logic                       bus_b_sel,
  input  wire logic                       format_check_enable,
  input  wire logic [2:0]                 ctl_flags,
  input  wire bcmbs_pkg::bcmbs_cmd_t      cmd1,
  input  wire bcmbs_pkg::bcmbs_cmd_t      cmd2,
  input  wire logic [15:0]                blk_base,
  input  wire logic [bcmbs_pkg::LOW_ERR_W-1:0] low_err,
  input  wire logic [TAG_W-1:0]           time_tag,
  input  wire logic                       ram_ack,
  output bcmbs_pkg::bcmbs_ram_req_t       ram_req_r,
  output logic                            ram_valid_r,
  output logic                            busy_r
);
  logic                 rst_s1_r;
  logic                 rst_n_r;
  bcmbs_pkg::bcmbs_state_t st_r;
  bcmbs_pkg::bcmbs_state_t st_nxt;
  logic                 message_done_flag_r;
  logic                 message_begun_flag_r;
  logic                 bus_used_flag_r;
  logic                 block_coding_error_flag_r;
  logic [TAG_W-1:0]     tag_r;
  logic [15:0]          base_r;
  logic                 code_err;
  logic                 pend_end_r;
  logic [15:0]          status_word;
  logic                 accept;
  logic                 busy_nxt;

  // Two-stage reset release; async assert only
  // Every other register resets from the synchronised copy
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  bcmbs_fmt_check u_chk (
    .chk_en    (format_check_enable),
    .ctl_flags (ctl_flags),
    .cmd1      (cmd1),
    .cmd2      (cmd2),
    .code_err  (code_err)
  );

  assign accept = ram_valid_r && ram_ack;

  always_comb begin
    status_word = {message_done_flag_r, message_begun_flag_r,
                   bus_used_flag_r, block_coding_error_flag_r, low_err};
  end

  // End remembered if it arrives while the start writes are in flight
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r)
      pend_end_r <= 1'b0;
    else if (msg_end && st_r != bcmbs_pkg::S_IDLE)
      pend_end_r <= 1'b1;
    else if (st_r == bcmbs_pkg::S_IDLE)
      pend_end_r <= 1'b0;
  end

  // A queued end keeps busy high through the idle cycle between the
  // start pair and the end pair; a start pulsed there wins and the queued
  // end is dropped; otherwise busy falls only once both pairs are stored
  always_comb begin
    busy_nxt = (st_nxt != bcmbs_pkg::S_IDLE) || pend_end_r ||
               (msg_end && (st_r != bcmbs_pkg::S_IDLE));
  end

  // Flags; bus and coding error hold from start to the end write
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      message_done_flag_r       <= 1'b0;
      message_begun_flag_r      <= 1'b0;
      bus_used_flag_r           <= 1'b0;
      block_coding_error_flag_r <= 1'b0;
      base_r                    <= bcmbs_pkg::WORD_ZERO;
    end else if (st_r == bcmbs_pkg::S_IDLE && msg_start) begin
      message_done_flag_r       <= 1'b0;
      message_begun_flag_r      <= 1'b1;
      bus_used_flag_r           <= bus_b_sel;
      block_coding_error_flag_r <= code_err;
      base_r                    <= blk_base;
    end else if (st_r == bcmbs_pkg::S_IDLE &&
                 (msg_end || pend_end_r)) begin
      message_done_flag_r       <= 1'b1;
      message_begun_flag_r      <= 1'b0;
    end
  end

  // Time tag snapshot at each flag change
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r)
      tag_r <= '0;
    else if (st_r == bcmbs_pkg::S_IDLE && (msg_start || msg_end ||
             pend_end_r))
      tag_r <= time_tag;
  end

  // Start and end each write the status word, then the low tag word
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      bcmbs_pkg::S_IDLE: begin
        if (msg_start)
          st_nxt = bcmbs_pkg::S_BEG_STAT;
        else if (msg_end || pend_end_r)
          st_nxt = bcmbs_pkg::S_END_STAT;
      end
      bcmbs_pkg::S_BEG_STAT: begin
        if (accept)
          st_nxt = bcmbs_pkg::S_BEG_TAG;
      end
      bcmbs_pkg::S_BEG_TAG: begin
        if (accept)
          st_nxt = bcmbs_pkg::S_IDLE;
      end
      bcmbs_pkg::S_END_STAT: begin
        if (accept)
          st_nxt = bcmbs_pkg::S_END_TAG;
      end
      bcmbs_pkg::S_END_TAG: begin
        if (accept)
          st_nxt = bcmbs_pkg::S_IDLE;
      end
      default: st_nxt = bcmbs_pkg::S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r)
      st_r <= bcmbs_pkg::S_IDLE;
    else
      st_r <= st_nxt;
  end

  // RAM write port; one word per state, held until acknowledged
  // One port for both words, so a pair is never interleaved
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ram_req_r   <= '0;
      ram_valid_r <= 1'b0;
      busy_r      <= 1'b0;
    end else begin
      busy_r <= busy_nxt;
      if (!ram_valid_r || accept) begin
        ram_valid_r <= 1'b0;
        ram_req_r.we <= 1'b0;
        case (st_nxt)
          bcmbs_pkg::S_BEG_STAT,
          bcmbs_pkg::S_END_STAT: begin
            if (st_nxt != st_r) begin
              ram_valid_r    <= 1'b1;
              ram_req_r.we   <= 1'b1;
              ram_req_r.addr <= blk_sel(st_nxt) + bcmbs_pkg::OFS_STATUS;
              ram_req_r.data <= next_word(st_nxt);
            end
          end
          bcmbs_pkg::S_BEG_TAG,
          bcmbs_pkg::S_END_TAG: begin
            if (st_nxt != st_r) begin
              ram_valid_r    <= 1'b1;
              ram_req_r.we   <= 1'b1;
              // Only the low tag word is stored; upper bits are dropped
              ram_req_r.addr <= base_r + bcmbs_pkg::OFS_TAG_LO;
              ram_req_r.data <= tag_r[15:0];
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Status words are formed from the values about to be latched
  function automatic logic [15:0] next_word(
    input bcmbs_pkg::bcmbs_state_t s);
    logic [15:0] w;
    w = status_word;
    if (s == bcmbs_pkg::S_BEG_STAT) begin
      w[bcmbs_pkg::DONE_BIT]  = 1'b0;
      w[bcmbs_pkg::BEGUN_BIT] = 1'b1;
      w[bcmbs_pkg::BUS_BIT]   = bus_b_sel;
      w[bcmbs_pkg::CODE_BIT]  = code_err;
    end else begin
      w[bcmbs_pkg::DONE_BIT]  = 1'b1;
      w[bcmbs_pkg::BEGUN_BIT] = 1'b0;
    end
    return w;
  endfunction

  function automatic logic [15:0] blk_sel(
    input bcmbs_pkg::bcmbs_state_t s);
    logic [15:0] b;
    b = (s == bcmbs_pkg::S_BEG_STAT) ? blk_base : base_r;
    return b;
  endfunction
endmodule // bcmbs_top

// File: tb/bcmbs_ram_model.sv
// Purpose: Shared RAM responder for the status word writer
// Assumes: 256 words decoded from the low address byte
// Notes:   Ack delay set by bench, 0 to 3 cycles
`timescale 1ns/1ps
module bcmbs_ram_model (
  input  wire logic                      sys_clk,
  input  wire bcmbs_pkg::bcmbs_ram_req_t ram_req_r,
  input  wire logic                      ram_valid_r,
  input  wire logic [1:0]                dly,
  input  wire logic                      host_we,
  input  wire logic [7:0]                host_addr,
  input  wire logic [15:0]               host_data,
  output logic                           ram_ack
);
  logic [15:0] mem [0:255]; // Host side writes it too
  logic [1:0]  wait_r = 2'h0;
  assign ram_ack = ram_valid_r && (wait_r == dly);
  always_ff @(posedge sys_clk) begin
    wait_r <= (ram_valid_r && !ram_ack) ? wait_r + 2'h1 : 2'h0;
    if (host_we) begin
      mem[host_addr] <= host_data;
    end
    if (ram_valid_r && ram_ack && ram_req_r.we) begin
      mem[ram_req_r.addr[7:0]] <= ram_req_r.data;
    end
  end
endmodule // bcmbs_ram_model

// File: tb/bcmbs_top_chk.sv
// Purpose: Port checks for the status word writer
// Assumes: Single clock, reset low
// Notes:   Tag words judged by the bench
`timescale 1ns/1ps
module bcmbs_top_chk (
  input wire logic                      sys_clk,
  input wire logic                      arst_n,
  input wire logic                      msg_start,
  input wire logic                      msg_end,
  input wire logic                      bus_b_sel,
  input wire logic                      format_check_enable,
  input wire logic [2:0]                ctl_flags,
  input wire bcmbs_pkg::bcmbs_cmd_t     cmd1,
  input wire logic [15:0]               blk_base,
  input wire logic                      ram_ack,
  input wire bcmbs_pkg::bcmbs_ram_req_t ram_req_r,
  input wire logic                      ram_valid_r,
  input wire logic                      busy_r
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  chk_start_flags: assert property (msg_start && !busy_r |=>
    ram_valid_r && ram_req_r.data[15:14] == 2'b01) else $error("start");
  chk_start_addr: assert property (msg_start && !busy_r |=>
    ram_req_r.addr == $past(blk_base)) else $error("addr");
  chk_bus_flag: assert property (msg_start && !busy_r |=>
    ram_req_r.data[13] == $past(bus_b_sel)) else $error("bus");
  chk_end_flags: assert property (msg_end && !busy_r |=>
    ram_valid_r && ram_req_r.data[15:14] == 2'b10) else $error("end");
  chk_req_hold: assert property (ram_valid_r && !ram_ack |=>
    ram_valid_r && $stable(ram_req_r)) else $error("hold");
  chk_end_queued: assert property (msg_end && busy_r |->
    ##[1:20] (ram_valid_r && ram_req_r.data[15:14] == 2'b10))
    else $error("queued");
  chk_valid_busy: assert property (ram_valid_r |-> busy_r)
    else $error("busy");
  chk_fmt_err: assert property (msg_start && !busy_r &&
    format_check_enable && ctl_flags[0] != (cmd1.rt == 5'h1f)
    |=> ram_req_r.data[12]) else $error("fmt");
  chk_bcast_tx: assert property (msg_start && !busy_r &&
    cmd1.rt == 5'h1f && cmd1.tx && cmd1.sa == 5'h05
    |=> ram_req_r.data[12]) else $error("bctx");
endmodule // bcmbs_top_chk
bind bcmbs_top bcmbs_top_chk chk_u (.*);

// File: tb/bcmbs_top_bench.sv
// Purpose: Scenario bench for the status word writer
// Assumes: RAM model answers with a set delay
// Notes:   Time tag held until writes finish
`timescale 1ns/1ps
module bcmbs_top_bench;
  logic sys_clk, arst_n, msg_start, msg_end, bus_b_sel, fce, ram_ack;
  logic [2:0]  ctl_flags;
  logic [15:0] cmd1, cmd2, blk_base;
  logic [11:0] low_err;
  logic [31:0] time_tag;
  logic [1:0]  dly;
  logic        host_we;
  logic [7:0]  host_addr;
  logic [15:0] host_data;
  logic        ram_valid_r, busy_r;
  bcmbs_pkg::bcmbs_ram_req_t ram_req_r;
  int n_mismatch = 0;
  int checks_done = 0;
  bcmbs_top #(.TAG_W(32)) dut_u (.sys_clk(sys_clk), .arst_n(arst_n),
    .msg_start(msg_start), .msg_end(msg_end), .bus_b_sel(bus_b_sel),
    .format_check_enable(fce), .ctl_flags(ctl_flags), .cmd1(cmd1),
    .cmd2(cmd2), .blk_base(blk_base), .low_err(low_err),
    .time_tag(time_tag), .ram_ack(ram_ack), .ram_req_r(ram_req_r),
    .ram_valid_r(ram_valid_r), .busy_r(busy_r));
  bcmbs_ram_model ram_u (.sys_clk(sys_clk), .ram_req_r(ram_req_r),
    .ram_valid_r(ram_valid_r), .dly(dly), .host_we(host_we),
    .host_addr(host_addr), .host_data(host_data), .ram_ack(ram_ack));
  task automatic finish_test();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Shared message run; mid checks only when end comes late
  task automatic run_msg(input logic [15:0] b, input logic bus, fc,
      input logic [2:0] fl, input logic [15:0] c1, c2,
      input int gap, input logic err);
    int n;
    @(posedge sys_clk);
    blk_base <= b; bus_b_sel <= bus; fce <= fc; ctl_flags <= fl;
    cmd1 <= c1; cmd2 <= c2; time_tag <= {16'h0000, b + 16'h1234};
    msg_start <= 1'b1;
    @(posedge sys_clk);
    msg_start <= 1'b0;
    repeat (gap) @(posedge sys_clk);
    if (gap > 8) begin
      check("mid_word", ram_u.mem[b[7:0]], {2'b01, bus, err, low_err});
      check("start_tag", ram_u.mem[b[7:0] + 8'h01], b + 16'h1234);
    end
    time_tag <= {16'h0000, b + 16'h4321};
    msg_end <= 1'b1;
    @(posedge sys_clk);
    msg_end <= 1'b0;
    repeat (2) @(posedge sys_clk);
    for (n = 0; (busy_r !== 1'b0 || ram_valid_r !== 1'b0); n++) begin
      if (n > 60) begin
        n_mismatch++;
        finish_test();
      end
      @(posedge sys_clk);
    end
    check("end_word", ram_u.mem[b[7:0]], {2'b10, bus, err, low_err});
    check("end_tag", ram_u.mem[b[7:0] + 8'h01], b + 16'h4321);
  endtask
  task automatic sc_prompt_a();
    dly <= 2'h0;
    host_addr <= 8'h10;
    host_data <= 16'hffff;
    host_we <= 1'b1;
    @(posedge sys_clk);
    host_we <= 1'b0;
    @(posedge sys_clk);
    check("host_word", ram_u.mem[8'h10], 16'hffff);
    run_msg(16'h0010, 1'b0, 1'b1, 3'b000, 16'h2862, 16'h0000, 20, 1'b0);
  endtask
  task automatic sc_slow_b_queued();
    dly <= 2'h3;
    run_msg(16'h0020, 1'b1, 1'b1, 3'b000, 16'h2862, 16'h0000, 1, 1'b0);
  endtask
  task automatic sc_fmt_mismatch();
    dly <= 2'h1;
    run_msg(16'h0030, 1'b0, 1'b1, 3'b001, 16'h2862, 16'h0000, 20, 1'b1);
  endtask
  task automatic sc_bcast_tx();
    run_msg(16'h0040, 1'b1, 1'b0, 3'b001, 16'hfca2, 16'h0000, 20, 1'b1);
  endtask
  task automatic sc_rtrt_wc();
    run_msg(16'h0050, 1'b0, 1'b0, 3'b010, 16'h2862, 16'h3463, 20, 1'b1);
  endtask
  // Remaining coding error forms, enable off, and legal broadcast mode code
  task automatic sc_more_codes();
    dly <= 2'h2;
    low_err <= 12'h5a3;
    run_msg(16'h0060, 1'b0, 1'b0, 3'b101, 16'hfc02, 16'h0000, 20, 1'b1);
    run_msg(16'h0070, 1'b1, 1'b0, 3'b101, 16'hffe0, 16'h0000, 1, 1'b1);
    run_msg(16'h0080, 1'b0, 1'b0, 3'b101, 16'hfc11, 16'h0000, 20, 1'b1);
    run_msg(16'h0090, 1'b1, 1'b0, 3'b010, 16'h2862, 16'h3062, 20, 1'b1);
    run_msg(16'h00d0, 1'b0, 1'b0, 3'b010, 16'h2c62, 16'h3462, 20, 1'b1);
    run_msg(16'h00a0, 1'b0, 1'b1, 3'b100, 16'h2862, 16'h0000, 20, 1'b1);
    run_msg(16'h00b0, 1'b0, 1'b0, 3'b100, 16'h2862, 16'h0000, 20, 1'b0);
    run_msg(16'h00c0, 1'b1, 1'b1, 3'b101, 16'hfc01, 16'h0000, 20, 1'b0);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    arst_n = 1'b0; msg_start = 1'b0; msg_end = 1'b0; bus_b_sel = 1'b0;
    fce = 1'b0; ctl_flags = 3'b000; cmd1 = 16'h0000; cmd2 = 16'h0000;
    blk_base = 16'h0000; low_err = 12'h0a5; time_tag = 32'h0000_0000;
    dly = 2'h0;
    host_we = 1'b0;
    host_addr = 8'h00;
    host_data = 16'h0000;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check("reset_valid", {15'h0000, ram_valid_r}, 16'h0000);
    check("reset_busy", {15'h0000, busy_r}, 16'h0000);
    check("reset_data", ram_req_r.data, 16'h0000);
    sc_prompt_a();
    sc_slow_b_queued();
    sc_fmt_mismatch();
    sc_bcast_tx();
    sc_rtrt_wc();
    sc_more_codes();
    finish_test();
  end
endmodule // bcmbs_top_bench
